// File: pse_pkg.sv
// Package for the port status and event register block: offsets, resets, state layout.
package pse_pkg;

  localparam int          PSE_MAX_PORTS = 31;
  localparam int          PSE_ADDR_W    = 8;
  localparam int          PSE_TMO_BIT   = 31;

  // Whole-register access
  localparam logic [7:0]  PSE_OFF_LEVEL     = 8'h00;
  localparam logic [7:0]  PSE_OFF_RISE      = 8'h04;
  localparam logic [7:0]  PSE_OFF_FALL      = 8'h08;
  localparam logic [7:0]  PSE_OFF_EVENT     = 8'h0C;
  localparam logic [7:0]  PSE_OFF_EVMASK    = 8'h10;
  localparam logic [7:0]  PSE_OFF_CERR      = 8'h14;
  localparam logic [7:0]  PSE_OFF_CMASK     = 8'h18;
  // Single-port access through the port selector
  localparam logic [7:0]  PSE_OFF_SEL       = 8'h20;
  localparam logic [7:0]  PSE_OFF_BIT_LEVEL = 8'h24;
  localparam logic [7:0]  PSE_OFF_BIT_RISE  = 8'h28;
  localparam logic [7:0]  PSE_OFF_BIT_FALL  = 8'h2C;
  localparam logic [7:0]  PSE_OFF_BIT_EVENT = 8'h30;
  localparam logic [7:0]  PSE_OFF_BIT_EVMSK = 8'h34;
  localparam logic [7:0]  PSE_OFF_BIT_CERR  = 8'h38;
  localparam logic [7:0]  PSE_OFF_BIT_CMASK = 8'h3C;
  // Interrupt status (write one to clear) and mask
  localparam logic [7:0]  PSE_OFF_IRQ_STS   = 8'h40;
  localparam logic [7:0]  PSE_OFF_IRQ_MASK  = 8'h44;

  localparam int          PSE_IRQ_EVENT_BIT = 0;
  localparam int          PSE_IRQ_CERR_BIT  = 1;

  localparam logic [31:0] PSE_RISE_RST      = 32'h0000_0000;
  localparam logic [31:0] PSE_FALL_RST      = 32'h0000_0000;
  localparam logic [31:0] PSE_MASK_RST      = 32'h0000_0000;
  localparam logic [1:0]  PSE_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  PSE_RESP_SLVERR   = 2'h2;

  typedef struct packed {
    logic [31:0] sync1;
    logic [31:0] sync2;
    logic [31:0] prev;
    logic [31:0] rise;
    logic [31:0] fall;
    logic [31:0] ev;
    logic [31:0] evm;
    logic [31:0] cerr;
    logic [31:0] cmask;
    logic        tmo;
    logic [4:0]  sel;
    logic [1:0]  ists;
    logic [1:0]  imask;
    logic        summary;
    logic        irq;
    logic        awready;
    logic        aw_full;
    logic [7:0]  awaddr;
    logic        wready;
    logic        w_full;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pse_state_type;

  localparam pse_state_type PSE_STATE_RST = '{
    rise:    PSE_RISE_RST,
    fall:    PSE_FALL_RST,
    evm:     PSE_MASK_RST,
    cmask:   PSE_MASK_RST,
    awready: 1'b1,
    wready:  1'b1,
    arready: 1'b1,
    default: '0
  };

endpackage : pse_pkg

// File: pse_port_status.sv
// Port status and event register bank with an AXI4-Lite slave.
//
// Function
// - Each port owns one bit of the level register, readable whole or one selected port at a time.
// - The level register returns the live synchronised status line of each port, with no latching or side effect.
// - Rise and fall select registers are read-write, one bit per port, each bit addressable on its own.
// - An event bit is set only by a status change in a direction enabled in the rise or fall select register.
// - Reset clears both select registers so no transition makes an event until software enables one.
// - The event register reads either whole or as the one bit of the selected port.
// - Reading the event register clears exactly the bits returned: one bit for a single-port read, all for a full read.
// - The event mask is read-write, one bit per port, accessible whole or per port.
// - Bit p of the comm error register belongs to port p, so several errors show as several bits.
// - Reading the comm error register clears the returned bits except the timeout summary bit, which follows its source.
// - The comm error mask is read-write, one bit per port, accessible whole or per port.
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module pse_port_status
  import pse_pkg::*;
#(
  parameter int NUM_PORTS = 16
)(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [NUM_PORTS-1:0]  module_status_in,
  input  wire logic [NUM_PORTS-1:0]  comm_error_in,
  input  wire logic                  timeout_summary_bit,
  output logic                       summary_out,
  output logic                       irq,
  input  wire logic [PSE_ADDR_W-1:0] awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [PSE_ADDR_W-1:0] araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready
);

  localparam logic [31:0] PORT_MASK = 32'((64'h1 << NUM_PORTS) - 64'h1);

  pse_state_type s_r;
  pse_state_type s_nxt;

  // Byte-lane merge for whole-register writes
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] d, input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return res & PORT_MASK;
  endfunction : merge

  // Single-port write of data bit 0 into the selected position
  function automatic logic [31:0] put_bit(input logic [31:0] old_v, input logic [4:0] idx, input logic b);
    logic [31:0] res;
    res = old_v;
    res[idx] = b;
    return res;
  endfunction : put_bit

  logic        sel_ok;
  logic [31:0] sel_one;
  logic [31:0] ev_set;
  logic [31:0] ev_clr;
  logic [31:0] cerr_set;
  logic [31:0] cerr_clr;
  logic [31:0] cerr_word;
  logic [31:0] rd_val;
  logic [1:0]  rd_resp;
  logic [1:0]  wr_resp;
  logic [1:0]  ists_clr;
  logic        do_read;
  logic        do_write;
  logic        bit_w;
  logic [31:0] edge_hit;

  // Per-port transition detect on the settled level; positions past the last port never fire
  for (genvar p = 0; p < 32; p++)
  begin : g_edge
    if (p < NUM_PORTS)
    begin : g_used
      logic went_up;
      logic went_down;
      assign went_up     = s_r.sync2[p] & ~s_r.prev[p];
      assign went_down   = ~s_r.sync2[p] & s_r.prev[p];
      assign edge_hit[p] = (went_up & s_r.rise[p]) | (went_down & s_r.fall[p]);
    end : g_used
    else
    begin : g_unused
      assign edge_hit[p] = 1'b0;
    end : g_unused
  end : g_edge

  always_comb
  begin
    s_nxt    = s_r;
    sel_ok   = 32'(s_r.sel) < NUM_PORTS;
    sel_one  = 32'h0000_0001 << s_r.sel;
    ev_clr   = 32'h0000_0000;
    cerr_clr = 32'h0000_0000;
    ists_clr = 2'h0;
    rd_val   = 32'h0000_0000;
    rd_resp  = PSE_RESP_OKAY;
    wr_resp  = PSE_RESP_OKAY;
    bit_w    = s_r.wdata[0] & s_r.wstrb[0];

    // Two-stage synchroniser on the module status pins; prev holds the last settled level
    s_nxt.sync1 = 32'(module_status_in);
    s_nxt.sync2 = s_r.sync1;
    s_nxt.prev  = s_r.sync2;
    s_nxt.tmo   = timeout_summary_bit;

    // Only enabled directions make events
    ev_set   = edge_hit;
    cerr_set = 32'(comm_error_in) & PORT_MASK;
    cerr_word = s_r.cerr | (32'(s_r.tmo) << PSE_TMO_BIT);

    // Read channel
    do_read = arvalid && s_r.arready;
    if (do_read)
    begin
      unique case (araddr)
        PSE_OFF_LEVEL:     rd_val = s_r.sync2 & PORT_MASK;
        PSE_OFF_RISE:      rd_val = s_r.rise;
        PSE_OFF_FALL:      rd_val = s_r.fall;
        PSE_OFF_EVENT:
        begin
          rd_val = s_r.ev;
          ev_clr = s_r.ev;
        end
        PSE_OFF_EVMASK:    rd_val = s_r.evm;
        PSE_OFF_CERR:
        begin
          rd_val   = cerr_word;
          cerr_clr = s_r.cerr;
        end
        PSE_OFF_CMASK:     rd_val = s_r.cmask;
        PSE_OFF_SEL:       rd_val = 32'(s_r.sel);
        PSE_OFF_IRQ_STS:   rd_val = 32'(s_r.ists);
        PSE_OFF_IRQ_MASK:  rd_val = 32'(s_r.imask);
        PSE_OFF_BIT_LEVEL: rd_val = 32'(s_r.sync2[s_r.sel]);
        PSE_OFF_BIT_RISE:  rd_val = 32'(s_r.rise[s_r.sel]);
        PSE_OFF_BIT_FALL:  rd_val = 32'(s_r.fall[s_r.sel]);
        PSE_OFF_BIT_EVENT:
        begin
          rd_val = 32'(s_r.ev[s_r.sel]);
          ev_clr = sel_ok ? sel_one : 32'h0000_0000;
        end
        PSE_OFF_BIT_EVMSK: rd_val = 32'(s_r.evm[s_r.sel]);
        PSE_OFF_BIT_CERR:
        begin
          rd_val   = 32'(s_r.cerr[s_r.sel]);
          cerr_clr = sel_ok ? sel_one : 32'h0000_0000;
        end
        PSE_OFF_BIT_CMASK: rd_val = 32'(s_r.cmask[s_r.sel]);
        default:           rd_resp = PSE_RESP_SLVERR;
      endcase
      // Per-port windows with a selector beyond the last port answer an error
      if (araddr >= PSE_OFF_BIT_LEVEL && araddr <= PSE_OFF_BIT_CMASK && !sel_ok)
      begin
        rd_resp = PSE_RESP_SLVERR;
        rd_val  = 32'h0000_0000;
      end
      s_nxt.rdata   = rd_val;
      s_nxt.rresp   = rd_resp;
      s_nxt.rvalid  = 1'b1;
      s_nxt.arready = 1'b0;
    end
    else if (s_r.rvalid && rready)
    begin
      s_nxt.rvalid  = 1'b0;
      s_nxt.arready = 1'b1;
    end

    // Write channels, taken in either order
    if (awvalid && s_r.awready)
    begin
      s_nxt.awaddr  = awaddr;
      s_nxt.aw_full = 1'b1;
      s_nxt.awready = 1'b0;
    end
    if (wvalid && s_r.wready)
    begin
      s_nxt.wdata  = wdata;
      s_nxt.wstrb  = wstrb;
      s_nxt.w_full = 1'b1;
      s_nxt.wready = 1'b0;
    end

    // Runs one cycle after the later handshake, once both halves are held
    do_write = s_r.aw_full && s_r.w_full && !s_r.bvalid;
    if (do_write)
    begin
      unique case (s_r.awaddr)
        PSE_OFF_RISE:      s_nxt.rise  = merge(s_r.rise, s_r.wdata, s_r.wstrb);
        PSE_OFF_FALL:      s_nxt.fall  = merge(s_r.fall, s_r.wdata, s_r.wstrb);
        PSE_OFF_EVMASK:    s_nxt.evm   = merge(s_r.evm, s_r.wdata, s_r.wstrb);
        PSE_OFF_CMASK:
        begin
          s_nxt.cmask = merge(s_r.cmask, s_r.wdata, s_r.wstrb);
          if (s_r.wstrb[3])
          begin
            s_nxt.cmask[PSE_TMO_BIT] = s_r.wdata[PSE_TMO_BIT];
          end
        end
        PSE_OFF_SEL:
        begin
          if (s_r.wstrb[0])
          begin
            s_nxt.sel = s_r.wdata[4:0];
          end
        end
        PSE_OFF_IRQ_STS:   ists_clr = s_r.wstrb[0] ? s_r.wdata[1:0] : 2'h0;
        PSE_OFF_IRQ_MASK:
        begin
          if (s_r.wstrb[0])
          begin
            s_nxt.imask = s_r.wdata[1:0];
          end
        end
        PSE_OFF_BIT_RISE:  s_nxt.rise  = put_bit(s_r.rise, s_r.sel, bit_w);
        PSE_OFF_BIT_FALL:  s_nxt.fall  = put_bit(s_r.fall, s_r.sel, bit_w);
        PSE_OFF_BIT_EVMSK: s_nxt.evm   = put_bit(s_r.evm, s_r.sel, bit_w);
        PSE_OFF_BIT_CMASK: s_nxt.cmask = put_bit(s_r.cmask, s_r.sel, bit_w);
        PSE_OFF_LEVEL, PSE_OFF_EVENT, PSE_OFF_CERR,
        PSE_OFF_BIT_LEVEL, PSE_OFF_BIT_EVENT, PSE_OFF_BIT_CERR:
          wr_resp = PSE_RESP_OKAY;
        default:           wr_resp = PSE_RESP_SLVERR;
      endcase
      if (s_r.awaddr >= PSE_OFF_BIT_LEVEL && s_r.awaddr <= PSE_OFF_BIT_CMASK && !sel_ok)
      begin
        // Out-of-range selector: undo any per-port update and report an error
        s_nxt.rise  = s_r.rise;
        s_nxt.fall  = s_r.fall;
        s_nxt.evm   = s_r.evm;
        s_nxt.cmask = s_r.cmask;
        wr_resp     = PSE_RESP_SLVERR;
      end
      s_nxt.bresp   = wr_resp;
      s_nxt.bvalid  = 1'b1;
      s_nxt.aw_full = 1'b0;
      s_nxt.w_full  = 1'b0;
    end
    else if (s_r.bvalid && bready)
    begin
      s_nxt.bvalid  = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready  = 1'b1;
    end

    // Sticky bits: a new event in the clearing cycle survives
    s_nxt.ev   = (s_r.ev & ~ev_clr) | ev_set;
    s_nxt.cerr = (s_r.cerr & ~cerr_clr) | cerr_set;

    s_nxt.ists = (s_r.ists & ~ists_clr);
    s_nxt.ists[PSE_IRQ_EVENT_BIT] = s_nxt.ists[PSE_IRQ_EVENT_BIT] | (|ev_set);
    s_nxt.ists[PSE_IRQ_CERR_BIT]  = s_nxt.ists[PSE_IRQ_CERR_BIT] | (|cerr_set);

    s_nxt.summary = (|(s_nxt.ev & s_nxt.evm)) |
                    (|((s_nxt.cerr | (32'(s_nxt.tmo) << PSE_TMO_BIT)) & s_nxt.cmask));
    s_nxt.irq     = |(s_nxt.ists & s_nxt.imask);
  end

  // Synchronous reset loads the package reset image into every field
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_r <= PSE_STATE_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign summary_out = s_r.summary;
  assign irq         = s_r.irq;
  assign awready     = s_r.awready;
  assign wready      = s_r.wready;
  assign bvalid      = s_r.bvalid;
  assign bresp       = s_r.bresp;
  assign arready     = s_r.arready;
  assign rvalid      = s_r.rvalid;
  assign rdata       = s_r.rdata;
  assign rresp       = s_r.rresp;

endmodule : pse_port_status

// File: pse_port_status_asserts.sv
// Checker for the port status block: bus answers, responses and reset values.
`timescale 1ns/1ps
module pse_port_status_chk
  import pse_pkg::*;
(
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  timeout_summary_bit,
  input wire logic                  summary_out,
  input wire logic                  irq,
  input wire logic [PSE_ADDR_W-1:0] awaddr,
  input wire logic                  awvalid,
  input wire logic                  awready,
  input wire logic                  wvalid,
  input wire logic                  wready,
  input wire logic [1:0]            bresp,
  input wire logic                  bvalid,
  input wire logic                  bready,
  input wire logic [PSE_ADDR_W-1:0] araddr,
  input wire logic                  arvalid,
  input wire logic                  arready,
  input wire logic [31:0]           rdata,
  input wire logic [1:0]            rresp,
  input wire logic                  rvalid,
  input wire logic                  rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd;
    arvalid && arready;
  endsequence
  // Both write halves are parked for one cycle before the write runs
  sequence s_wr_parked;
    !awready && !wready ##1 (bvalid && !awready && !wready);
  endsequence
  sequence s_tmo_steady;
    araddr == PSE_OFF_CERR && $past(aresetn) && $stable(timeout_summary_bit);
  endsequence
  chk_write_answer: assert property (s_wr |=> s_wr_parked)
    else $error("write not answered two cycles after handshake");
  chk_read_answer: assert property (s_rd |=> rvalid && !arready)
    else $error("read not answered next cycle");
  chk_b_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  chk_r_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped early");
  chk_b_release: assert property (bvalid && bready |=> !bvalid && awready && wready)
    else $error("write channel not released");
  chk_bad_write: assert property (s_wr ##0 awaddr == 8'h1C |=> ##1 bresp == PSE_RESP_SLVERR)
    else $error("unmapped write not refused");
  chk_bad_read: assert property (s_rd ##0 araddr == 8'h1C |=> rresp == PSE_RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_level_ro: assert property (s_wr ##0 awaddr == PSE_OFF_LEVEL |=> ##1 bresp == PSE_RESP_OKAY)
    else $error("level write not accepted");
  chk_tmo_live: assert property (s_rd ##0 s_tmo_steady |=> rdata[31] == $past(timeout_summary_bit))
    else $error("timeout bit not live");
  chk_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !bvalid && !rvalid && !irq && !summary_out)
    else $error("outputs not cleared by reset");
endmodule : pse_port_status_chk

bind pse_port_status pse_port_status_chk pse_port_status_chk_i (.aclk, .aresetn, .timeout_summary_bit,
  .summary_out, .irq, .awaddr, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
  .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

// File: pse_plugin_model.sv
// Model of the plug-in modules driving status lines and comm error pulses.
`timescale 1ns/1ps
module pse_plugin_model #(
  parameter int NUM_PORTS = 16
)(
  input  wire logic                 aclk,
  input  wire logic [NUM_PORTS-1:0] lvl_cmd,
  input  wire logic [NUM_PORTS-1:0] err_cmd,
  output logic      [NUM_PORTS-1:0] status_line,
  output logic      [NUM_PORTS-1:0] err_pulse
);
  // Lines move just after an edge, like a module on its own timing
  always_ff @(posedge aclk)
  begin
    status_line <= lvl_cmd;
    err_pulse   <= err_cmd;
  end
endmodule : pse_plugin_model

// File: test_pse_port_status.sv
// Self-checking bench for the port status and event register block.
`timescale 1ns/1ps
module test_pse_port_status
  import pse_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic [31:0] d, rst, e;} pse_row_type;
  logic        aclk = 1'b0, aresetn = 1'b0, timeout_summary_bit = 1'b0, summary_out, irq;
  logic [15:0] module_status_in, comm_error_in, lvl_cmd = '0, err_cmd = '0;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, d;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  int          n_fail = 0, n_checks = 0;
  pse_row_type rows [11] = '{
    '{8'h04, 32'hFFFFFFFF, 32'h0, 32'h0000FFFF}, '{8'h08, 32'hFFFFFFFF, 32'h0, 32'h0000FFFF},
    '{8'h10, 32'hFFFFFFFF, 32'h0, 32'h0000FFFF}, '{8'h18, 32'hFFFFFFFF, 32'h0, 32'h8000FFFF},
    '{8'h44, 32'hFFFFFFFF, 32'h0, 32'h3}, '{8'h00, 32'hFFFFFFFF, 32'h0, 32'h0}, '{8'h20, 32'h5, 32'h0, 32'h5},
    '{8'h28, 32'h0, 32'h1, 32'h0}, '{8'h2C, 32'h0, 32'h1, 32'h0}, '{8'h34, 32'h0, 32'h1, 32'h0},
    '{8'h3C, 32'h0, 32'h1, 32'h0}};

  always #25 aclk = ~aclk;

  pse_port_status #(.NUM_PORTS(16)) pse_port_status_i (.aclk, .aresetn, .module_status_in, .comm_error_in,
    .timeout_summary_bit, .summary_out, .irq, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  pse_plugin_model #(.NUM_PORTS(16)) pse_plugin_model_i (.aclk, .lvl_cmd, .err_cmd,
    .status_line(module_status_in), .err_pulse(comm_error_in));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // Ready is raised on the second edge, together with bvalid, so the hold-off path is not used
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int k;
    logic done;
    k = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      done = bvalid && bready;
      rs = bresp;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      bready <= (k > 0) && !done;
      k++;
    end
    while (!done);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int k;
    logic done;
    k = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      done = rvalid && rready;
      v = rdata;
      rs = rresp;
      if (arready)
        arvalid <= 1'b0;
      rready <= (k > 0) && !done;
      k++;
    end
    while (!done);
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] rs;
    rd(a, v, rs);
    check(v, e);
  endtask : rc

  initial
  begin
    repeat (4000) @(posedge aclk);
    n_fail++;
    give_verdict;
  end

  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 11; i++)
    begin
      rc(rows[i].a, rows[i].rst);
      wr(rows[i].a, rows[i].d, r);
      check({30'h0, r}, {30'h0, PSE_RESP_OKAY});
      rc(rows[i].a, rows[i].e);
    end
    $display("end of register rows");
    wr(PSE_OFF_RISE, 32'h8, r);
    wr(PSE_OFF_FALL, 32'h20, r);
    wr(PSE_OFF_EVMASK, 32'h8, r);
    lvl_cmd <= 16'h0038;
    repeat (8) @(posedge aclk);
    check({31'h0, summary_out}, 32'h1);
    rc(PSE_OFF_LEVEL, 32'h38);
    wr(PSE_OFF_SEL, 32'h4, r);
    rc(PSE_OFF_BIT_LEVEL, 32'h1);
    lvl_cmd <= 16'h0000;
    repeat (8) @(posedge aclk);
    rc(PSE_OFF_LEVEL, 32'h0);
    wr(PSE_OFF_SEL, 32'h5, r);
    rc(PSE_OFF_BIT_EVENT, 32'h1);
    rc(PSE_OFF_EVENT, 32'h8);
    rc(PSE_OFF_EVENT, 32'h0);
    check({31'h0, summary_out}, 32'h0);
    $display("end of status events");
    timeout_summary_bit <= 1'b1;
    err_cmd <= 16'h0090;
    @(posedge aclk);
    err_cmd <= 16'h0000;
    repeat (4) @(posedge aclk);
    rc(PSE_OFF_CERR, 32'h80000090);
    rc(PSE_OFF_CERR, 32'h80000000);
    err_cmd <= 16'h0090;
    @(posedge aclk);
    err_cmd <= 16'h0000;
    wr(PSE_OFF_SEL, 32'h7, r);
    rc(PSE_OFF_BIT_CERR, 32'h1);
    rc(PSE_OFF_CERR, 32'h80000010);
    check({31'h0, summary_out}, 32'h1);
    timeout_summary_bit <= 1'b0;
    repeat (4) @(posedge aclk);
    check({31'h0, summary_out}, 32'h0);
    $display("end of comm errors");
    rc(PSE_OFF_IRQ_STS, 32'h3);
    check({31'h0, irq}, 32'h1);
    wr(PSE_OFF_IRQ_MASK, 32'h0, r);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 32'h0);
    wr(PSE_OFF_IRQ_MASK, 32'h3, r);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 32'h1);
    wr(PSE_OFF_IRQ_STS, 32'h3, r);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 32'h0);
    $display("end of interrupt");
    wr(8'h1C, 32'h1, r);
    check({30'h0, r}, {30'h0, PSE_RESP_SLVERR});
    rd(8'h1C, d, r);
    check({30'h0, r}, {30'h0, PSE_RESP_SLVERR});
    wr(PSE_OFF_SEL, 32'h14, r);
    rd(PSE_OFF_BIT_LEVEL, d, r);
    check({30'h0, r}, {30'h0, PSE_RESP_SLVERR});
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rc(PSE_OFF_RISE, 32'h0);
    rc(PSE_OFF_FALL, 32'h0);
    $display("end of refusals and reset");
    give_verdict;
  end
endmodule : test_pse_port_status
